/* inc/dsp_regs_pkg.sv */
// constants and carrier types for the processor/dsp register file
// assumes one core clock; decode and datapaths sit outside this block
package dsp_regs_pkg;
	localparam int ACC_W      = 40;
	localparam int WORD_W     = 32;
	localparam int GUARD_W    = 8;
	localparam logic [31:0] PTR_STEP   = 32'h0000_0004;
	localparam logic [31:0] PC_AHEAD   = 32'h0000_0004;
	localparam int FLG_GREATER = 7;
	localparam int FLG_NULL    = 6;
	localparam int FLG_BELOW   = 5;
	localparam int FLG_SUM_EXC = 4;
	localparam int FLG_SEL_LO  = 1;
	localparam int FLG_COND    = 0;
	localparam logic [31:0] FLAGS_RESET  = 32'h0000_0000;
	localparam logic [31:0] FLAGS_MASK   = 32'h0000_00FF;
	localparam logic [31:0] STATUS_RESET = 32'h0000_00F0;
	localparam logic [31:0] STATUS_MASK  = 32'h0FFF_0FFF;
	localparam int ST_COUNT_LO = 16;
	localparam int ST_YWRAP    = 11;
	localparam int ST_XWRAP    = 10;
	localparam int ST_STEP_HI  = 3;
	localparam int ST_STEP_LO  = 2;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	// condition select codes
	localparam logic [2:0] SEL_CARRY   = 3'h0;
	localparam logic [2:0] SEL_NEG     = 3'h1;
	localparam logic [2:0] SEL_ZERO    = 3'h2;
	localparam logic [2:0] SEL_OVF     = 3'h3;
	localparam logic [2:0] SEL_SGT     = 3'h4;
	localparam logic [2:0] SEL_SABOVE  = 3'h5;

	// control register selector for load/store
	typedef enum logic [1:0] {
		CTRL_LOOP_BEGIN,
		CTRL_LOOP_FINISH,
		CTRL_WRAP
	} ctrl_sel_t;

	// system register selector for core moves
	typedef enum logic [3:0] {
		SYS_MAC_HIGH,
		SYS_MAC_LOW,
		SYS_RETURN,
		SYS_PC,
		SYS_ACC0,
		SYS_XDAT0,
		SYS_XDAT1,
		SYS_YDAT0,
		SYS_YDAT1,
		SYS_FLAGS
	} sys_sel_t;

	// dsp destination selector
	typedef enum logic [2:0] {
		DST_ACC0,
		DST_ACC1,
		DST_MUL0,
		DST_MUL1,
		DST_X0,
		DST_X1,
		DST_Y0,
		DST_Y1
	} dsp_dst_t;

	typedef enum logic [1:0] {
		ADDR_REG,
		ADDR_POST_INC,
		ADDR_PRE_DEC
	} ctrl_addr_t;

	// control load/store request
	typedef struct packed {
		logic         load;
		logic         store;
		ctrl_sel_t    sel;
		ctrl_addr_t   mode;
		logic [31:0]  gpr_data;
		logic [31:0]  pointer;
	} ctrl_req_t;

	// dsp result bundle from the execution pipeline
	typedef struct packed {
		logic         valid;
		logic         conditional;
		logic         no_flag_update;
		logic         write_en;
		dsp_dst_t     dst;
		logic [39:0]  result;
		logic         carry;
		logic         compare;
		logic         cmp_greater;
		logic         cmp_equal;
		logic         cmp_less;
	} dsp_res_t;
endpackage

/* rtl/cpu_dsp_register_file.sv */
// processor register file: loop/wrap, status word, system and dsp registers
// assumes pipeline supplies decoded requests, one per kind per cycle
`timescale 1ns/100ps
module cpu_dsp_register_file (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire dsp_regs_pkg::ctrl_req_t ctrl_req,
	output logic [31:0]                  ctrl_rdata,
	output logic [31:0]                  ctrl_ptr_next,
	input  wire logic                    loop_set_begin,
	input  wire logic                    loop_set_finish,
	input  wire logic [11:0]             loop_disp,
	input  wire logic [31:0]             exec_pc,
	input  wire logic                    pc_load,
	input  wire logic [31:0]             pc_target,
	input  wire logic                    status_we,
	input  wire logic [31:0]             status_wdata,
	output logic [31:0]                  cpu_status_word,
	output logic [31:0]                  loop_begin_addr,
	output logic [31:0]                  loop_finish_addr,
	output logic [31:0]                  wrap_bounds,
	input  wire logic                    legacy_mac_we,
	input  wire logic [63:0]             legacy_mac_data,
	input  wire logic                    parallel_mul_op,
	input  wire logic                    call_taken,
	input  wire logic [31:0]             call_return_addr,
	input  wire logic                    sys_we,
	input  wire dsp_regs_pkg::sys_sel_t  sys_sel,
	input  wire logic [31:0]             sys_wdata,
	output logic [31:0]                  sys_rdata,
	input  wire dsp_regs_pkg::dsp_res_t  dsp_res,
	output logic [39:0]                  accumulator_zero,
	output logic [39:0]                  accumulator_one,
	output logic [31:0]                  dsp_flags_reg,
	output logic                         dsp_cond_flag,
	output logic                         dsp_exec_taken
);
	logic [31:0] mul_acc_high;
	logic [31:0] mul_acc_low;
	logic [31:0] return_link;
	logic [31:0] program_counter;
	logic [31:0] dat [2:7];
	logic [7:0]  guard_zero;
	logic [7:0]  guard_one;

	assign guard_zero = accumulator_zero[39:32];
	assign guard_one  = accumulator_one[39:32];

	// control register selection
	function automatic logic [31:0] ctrl_pick(input dsp_regs_pkg::ctrl_sel_t s,
		input logic [31:0] b, input logic [31:0] f, input logic [31:0] w);
		case (s)
			dsp_regs_pkg::CTRL_LOOP_BEGIN:  ctrl_pick = b;
			dsp_regs_pkg::CTRL_LOOP_FINISH: ctrl_pick = f;
			default:                        ctrl_pick = w;
		endcase
	endfunction

	// control load value and pointer arithmetic
	wire         ld_mem      = ctrl_req.mode == dsp_regs_pkg::ADDR_POST_INC;
	wire         st_mem      = ctrl_req.mode == dsp_regs_pkg::ADDR_PRE_DEC;
	wire [31:0]  ptr_inc     = ctrl_req.pointer + dsp_regs_pkg::PTR_STEP;
	wire [31:0]  ptr_dec     = ctrl_req.pointer - dsp_regs_pkg::PTR_STEP;
	wire [31:0]  disp_word   = {{19{loop_disp[11]}}, loop_disp, 1'b0};
	wire [31:0]  loop_target = exec_pc + disp_word;
	wire         wr_begin    = ctrl_req.load && ctrl_req.sel == dsp_regs_pkg::CTRL_LOOP_BEGIN;
	wire         wr_finish   = ctrl_req.load && ctrl_req.sel == dsp_regs_pkg::CTRL_LOOP_FINISH;
	wire         wr_wrap     = ctrl_req.load && ctrl_req.sel == dsp_regs_pkg::CTRL_WRAP;
	wire [31:0]  next_ptr    = ctrl_req.load && ld_mem ? ptr_inc :
	                           ctrl_req.store && st_mem ? ptr_dec : ctrl_req.pointer;

	// loop and wrap registers; written the cycle of the load so the next op sees them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			loop_begin_addr  <= 32'h0000_0000;
			loop_finish_addr <= 32'h0000_0000;
			wrap_bounds      <= 32'h0000_0000;
		end else begin
			if (wr_begin)
				loop_begin_addr <= ctrl_req.gpr_data;
			else if (loop_set_begin)
				loop_begin_addr <= loop_target;
			if (wr_finish)
				loop_finish_addr <= ctrl_req.gpr_data;
			else if (loop_set_finish)
				loop_finish_addr <= loop_target;
			if (wr_wrap)
				wrap_bounds <= ctrl_req.gpr_data;
		end
	end

	// store data and pointer update back to the core, registered
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_rdata    <= 32'h0000_0000;
			ctrl_ptr_next <= 32'h0000_0000;
		end else begin
			ctrl_rdata    <= ctrl_pick(ctrl_req.sel, loop_begin_addr, loop_finish_addr,
			                           wrap_bounds);
			ctrl_ptr_next <= next_ptr;
		end
	end

	// status word: loop_count, wrap enables, step code; reserved bits forced low
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			cpu_status_word <= dsp_regs_pkg::STATUS_RESET;
		else if (status_we)
			cpu_status_word <= status_wdata & dsp_regs_pkg::STATUS_MASK;
	end

	// system register writes
	wire w_mul_acc_high = sys_we && sys_sel == dsp_regs_pkg::SYS_MAC_HIGH;
	wire w_mul_acc_low = sys_we && sys_sel == dsp_regs_pkg::SYS_MAC_LOW;
	wire w_ret  = sys_we && sys_sel == dsp_regs_pkg::SYS_RETURN;
	// parallel multiply result never lands here
	wire mac_up = legacy_mac_we && !parallel_mul_op;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mul_acc_high <= 32'h0000_0000;
			mul_acc_low  <= 32'h0000_0000;
			return_link  <= 32'h0000_0000;
		end else begin
			if (mac_up) begin
				mul_acc_high <= legacy_mac_data[63:32];
				mul_acc_low  <= legacy_mac_data[31:0];
			end else begin
				if (w_mul_acc_high)
					mul_acc_high <= sys_wdata;
				if (w_mul_acc_low)
					mul_acc_low <= sys_wdata;
			end
			if (call_taken)
				return_link <= call_return_addr;
			else if (w_ret)
				return_link <= sys_wdata;
		end
	end

	// program counter tracks the executing instruction plus four unless pc_load loads pc_target
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			program_counter <= dsp_regs_pkg::PC_RESET;
		else if (pc_load)
			program_counter <= pc_target;
		else
			program_counter <= exec_pc + dsp_regs_pkg::PC_AHEAD;
	end

	// dsp flag computation, guard byte used for sign and overflow
	wire        res_neg  = dsp_res.result[39];
	wire        res_zero = dsp_res.result == 40'h00_0000_0000;
	wire        res_ovf  = dsp_res.result[39:32] != {8{dsp_res.result[31]}};
	wire        f_gt     = dsp_res.compare ? dsp_res.cmp_greater : (!res_neg && !res_zero);
	wire        f_z      = dsp_res.compare ? dsp_res.cmp_equal : res_zero;
	wire        f_n      = dsp_res.compare ? dsp_res.cmp_less : res_neg;
	wire [2:0]  sel      = dsp_flags_reg[3:1];
	logic       cond_hit;
	always_comb begin
		case (sel)
			dsp_regs_pkg::SEL_CARRY:  cond_hit = dsp_res.carry;
			dsp_regs_pkg::SEL_NEG:    cond_hit = f_n;
			dsp_regs_pkg::SEL_ZERO:   cond_hit = f_z;
			dsp_regs_pkg::SEL_OVF:    cond_hit = res_ovf;
			dsp_regs_pkg::SEL_SGT:    cond_hit = f_gt;
			dsp_regs_pkg::SEL_SABOVE: cond_hit = !f_n && !f_z; // signed above, magnitude sense
			default:                  cond_hit = 1'b0; // codes 110/111 not programmed
		endcase
	end

	// flags update only on unconditional processing; moves and pmul leave them
	wire flag_up = dsp_res.valid && !dsp_res.conditional && !dsp_res.no_flag_update;
	// conditional ops touch dsp registers only when the condition flag is set
	wire dsp_go  = dsp_res.valid && dsp_res.write_en &&
	               (!dsp_res.conditional || dsp_flags_reg[dsp_regs_pkg::FLG_COND]);
	wire [31:0] flags_new = {24'h00_0000, f_gt, f_z, f_n, res_ovf, sel, cond_hit};
	wire w_flags = sys_we && sys_sel == dsp_regs_pkg::SYS_FLAGS;
	// one next value feeds both the register and the condition output, so they never part
	wire [31:0] next_flags = flag_up ? flags_new :
	                         w_flags ? (sys_wdata & dsp_regs_pkg::FLAGS_MASK) :
	                         dsp_flags_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			dsp_flags_reg <= dsp_regs_pkg::FLAGS_RESET;
		else
			dsp_flags_reg <= next_flags;
	end

	// accumulator zero core write sign-fills guard byte
	wire w_acc0 = sys_we && sys_sel == dsp_regs_pkg::SYS_ACC0;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			accumulator_zero <= 40'h00_0000_0000;
			accumulator_one  <= 40'h00_0000_0000;
		end else begin
			if (dsp_go && dsp_res.dst == dsp_regs_pkg::DST_ACC0)
				accumulator_zero <= dsp_res.result;
			else if (w_acc0)
				accumulator_zero <= {{8{sys_wdata[31]}}, sys_wdata};
			if (dsp_go && dsp_res.dst == dsp_regs_pkg::DST_ACC1)
				accumulator_one <= dsp_res.result;
		end
	end

	// six 32-bit data registers; index follows dsp_dst_t encoding
	function automatic logic sys_hits(input dsp_regs_pkg::sys_sel_t s, input int i);
		case (i)
			4:       sys_hits = s == dsp_regs_pkg::SYS_XDAT0;
			5:       sys_hits = s == dsp_regs_pkg::SYS_XDAT1;
			6:       sys_hits = s == dsp_regs_pkg::SYS_YDAT0;
			7:       sys_hits = s == dsp_regs_pkg::SYS_YDAT1;
			default: sys_hits = 1'b0;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 2; gi < 8; gi++) begin : g_dat
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst)
					dat[gi] <= 32'h0000_0000;
				else if (dsp_go && dsp_res.dst == dsp_regs_pkg::dsp_dst_t'(gi))
					dat[gi] <= dsp_res.result[31:0];
				else if (sys_we && sys_hits(sys_sel, gi))
					dat[gi] <= sys_wdata;
			end
		end
	endgenerate

	// core-side system register read, registered
	logic [31:0] sys_mux;
	always_comb begin
		case (sys_sel)
			dsp_regs_pkg::SYS_MAC_HIGH: sys_mux = mul_acc_high;
			dsp_regs_pkg::SYS_MAC_LOW:  sys_mux = mul_acc_low;
			dsp_regs_pkg::SYS_RETURN:   sys_mux = return_link;
			dsp_regs_pkg::SYS_PC:       sys_mux = program_counter;
			dsp_regs_pkg::SYS_ACC0:     sys_mux = accumulator_zero[31:0];
			dsp_regs_pkg::SYS_XDAT0:    sys_mux = dat[4];
			dsp_regs_pkg::SYS_XDAT1:    sys_mux = dat[5];
			dsp_regs_pkg::SYS_YDAT0:    sys_mux = dat[6];
			dsp_regs_pkg::SYS_YDAT1:    sys_mux = dat[7];
			dsp_regs_pkg::SYS_FLAGS:    sys_mux = dsp_flags_reg & dsp_regs_pkg::FLAGS_MASK;
			default:                    sys_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sys_rdata      <= 32'h0000_0000;
			dsp_exec_taken <= 1'b0;
			dsp_cond_flag  <= 1'b0;
		end else begin
			sys_rdata      <= sys_mux;
			dsp_exec_taken <= dsp_go;
			dsp_cond_flag  <= next_flags[dsp_regs_pkg::FLG_COND];
		end
	end
endmodule

/* verification/cpu_dsp_register_file_properties.sv */
// assertion checker on the register file ports
// bound to every instance; one core clock, async reset
`timescale 1ns/100ps
module cpu_dsp_register_file_properties (
	input wire logic                    clk,
	input wire logic                    sys_rst,
	input wire dsp_regs_pkg::ctrl_req_t ctrl_req,
	input wire logic [31:0]             ctrl_ptr_next,
	input wire logic                    loop_set_begin,
	input wire logic [11:0]             loop_disp,
	input wire logic [31:0]             exec_pc,
	input wire logic [31:0]             loop_begin_addr,
	input wire logic [31:0]             cpu_status_word,
	input wire logic                    sys_we,
	input wire dsp_regs_pkg::sys_sel_t  sys_sel,
	input wire logic [31:0]             sys_wdata,
	input wire dsp_regs_pkg::dsp_res_t  dsp_res,
	input wire logic [39:0]             accumulator_zero,
	input wire logic [31:0]             dsp_flags_reg,
	input wire logic                    dsp_cond_flag
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// a core write to the flags in the same cycle is dropped, since the dsp update takes priority
	wire flag_wr = sys_we && sys_sel == dsp_regs_pkg::SYS_FLAGS;
	wire upd     = dsp_res.valid && !dsp_res.conditional && !dsp_res.no_flag_update;

	a_load_copy: assert property (
		ctrl_req.load && ctrl_req.sel == dsp_regs_pkg::CTRL_LOOP_BEGIN
		|=> loop_begin_addr == $past(ctrl_req.gpr_data)) else $error("loop start not loaded");
	a_post_inc: assert property (
		ctrl_req.load && ctrl_req.mode == dsp_regs_pkg::ADDR_POST_INC
		|=> ctrl_ptr_next == $past(ctrl_req.pointer) + 32'h4) else $error("bad post step");
	a_pre_dec: assert property (
		ctrl_req.store && ctrl_req.mode == dsp_regs_pkg::ADDR_PRE_DEC
		|=> ctrl_ptr_next == $past(ctrl_req.pointer) - 32'h4) else $error("bad pre step");
	a_loop_set: assert property (
		loop_set_begin && !ctrl_req.load |=> loop_begin_addr == $past(exec_pc)
		+ {{19{$past(loop_disp[11])}}, $past(loop_disp), 1'h0}) else $error("bad loop set");
	a_status_mask: assert property (
		(cpu_status_word & ~dsp_regs_pkg::STATUS_MASK) == 32'h0) else $error("status bits");
	a_acc_fill: assert property (
		sys_we && sys_sel == dsp_regs_pkg::SYS_ACC0 && !dsp_res.valid |=> accumulator_zero
		== {{8{$past(sys_wdata[31])}}, $past(sys_wdata)}) else $error("guard not filled");
	a_flags_upper: assert property (
		dsp_flags_reg[31:8] == 24'h0) else $error("flag upper bits set");
	a_ovf_flag: assert property (
		upd && !flag_wr |=> dsp_flags_reg[4] == ($past(dsp_res.result[39:32])
		!= {8{$past(dsp_res.result[31])}})) else $error("overflow flag wrong");
	a_cond_mirror: assert property (
		dsp_cond_flag == dsp_flags_reg[0]) else $error("condition flag mismatch");
	a_flags_frozen: assert property (
		dsp_res.valid && (dsp_res.conditional || dsp_res.no_flag_update) && !flag_wr
		|=> $stable(dsp_flags_reg)) else $error("flags changed");
endmodule

bind cpu_dsp_register_file cpu_dsp_register_file_properties i_props (
	.clk, .sys_rst, .ctrl_req, .ctrl_ptr_next, .loop_set_begin, .loop_disp, .exec_pc,
	.loop_begin_addr, .cpu_status_word, .sys_we, .sys_sel, .sys_wdata, .dsp_res,
	.accumulator_zero, .dsp_flags_reg, .dsp_cond_flag
);

/* verification/core_pipe_model.sv */
// core side model issuing system register writes
// combinational; the bench drives it just after each clock edge
`timescale 1ns/100ps
module core_pipe_model (
	input  wire logic                   cmd_we,
	input  wire dsp_regs_pkg::sys_sel_t cmd_sel,
	input  wire logic [31:0]            cmd_data,
	output logic                        sys_we,
	output dsp_regs_pkg::sys_sel_t      sys_sel,
	output logic [31:0]                 sys_wdata
);
	// software never sets reserved flag bits nor select codes 110 and 111
	wire flags = cmd_sel == dsp_regs_pkg::SYS_FLAGS;
	assign sys_sel   = cmd_sel;
	assign sys_wdata = flags ? (cmd_data & 32'h0000_00FF) : cmd_data;
	assign sys_we    = cmd_we && !(flags && cmd_data[3:2] == 2'h3);
endmodule

/* verification/tb.sv */
// self-checking bench for the processor/dsp register file
// core writes pass through core_pipe_model; checker is bound
`timescale 1ns/100ps
module tb;
	typedef struct {
		logic [2:0]  cs;
		logic [3:0]  cmp;
		logic [39:0] r;
		logic        cy;
		logic [7:0]  e;
	} row_t;
	// select code, compare bits, result, carry, expected flag byte
	row_t rows [8] = '{
		'{3'h0, 4'h0, 40'h00_0000_0001, 1'h1, 8'h81},
		'{3'h1, 4'h0, 40'hFF_FFFF_FFFF, 1'h0, 8'h23},
		'{3'h2, 4'h0, 40'h00_0000_0000, 1'h0, 8'h45},
		'{3'h3, 4'h0, 40'h00_8000_0000, 1'h0, 8'h97},
		'{3'h4, 4'h0, 40'h00_0000_0005, 1'h0, 8'h89},
		'{3'h5, 4'h0, 40'h00_0000_0000, 1'h0, 8'h4A},
		'{3'h0, 4'h0, 40'h7F_0000_0000, 1'h0, 8'h90},
		'{3'h2, 4'h9, 40'h00_0000_0005, 1'h0, 8'h24}};
	logic                    clk = 1'h0;
	logic                    sys_rst = 1'h1;
	dsp_regs_pkg::ctrl_req_t ctrl_req = '0;
	dsp_regs_pkg::dsp_res_t  dsp_res = '0;
	dsp_regs_pkg::sys_sel_t  csel = dsp_regs_pkg::SYS_MAC_HIGH;
	dsp_regs_pkg::sys_sel_t  sys_sel;
	logic loop_set_begin, loop_set_finish, pc_load, status_we, legacy_mac_we;
	logic parallel_mul_op, call_taken, cwe, sys_we, dsp_cond_flag, dsp_exec_taken;
	logic [11:0] loop_disp;
	logic [63:0] legacy_mac_data;
	logic [39:0] accumulator_zero, accumulator_one;
	logic [31:0] exec_pc, pc_target, status_wdata, call_return_addr, cdata, sys_wdata;
	logic [31:0] ctrl_rdata, ctrl_ptr_next, cpu_status_word, loop_begin_addr, sys_rdata;
	logic [31:0] loop_finish_addr, wrap_bounds, dsp_flags_reg;
	int          fails = 0;
	int          checked = 0;
	int          cycles = 0;

	cpu_dsp_register_file i_dut (
		.clk, .sys_rst, .ctrl_req, .ctrl_rdata, .ctrl_ptr_next, .loop_set_begin,
		.loop_set_finish, .loop_disp, .exec_pc, .pc_load, .pc_target, .status_we,
		.status_wdata, .cpu_status_word, .loop_begin_addr, .loop_finish_addr, .wrap_bounds,
		.legacy_mac_we, .legacy_mac_data, .parallel_mul_op, .call_taken, .call_return_addr,
		.sys_we, .sys_sel, .sys_wdata, .sys_rdata, .dsp_res, .accumulator_zero,
		.accumulator_one, .dsp_flags_reg, .dsp_cond_flag, .dsp_exec_taken);
	core_pipe_model i_pipe (.cmd_we(cwe), .cmd_sel(csel), .cmd_data(cdata), .sys_we, .sys_sel,
		.sys_wdata);

	// 250 MHz core clock, plus a hang guard far above the run length
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			conclude;
		end
	end

	// inputs always move 1 ns after the edge so sampling never races
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic sysw(input dsp_regs_pkg::sys_sel_t s, input logic [31:0] d);
		csel = s;
		cdata = d;
		cwe = 1'h1;
		tick;
		cwe = 1'h0;
	endtask
	task automatic rd(input dsp_regs_pkg::sys_sel_t s, input logic [31:0] e);
		csel = s;
		tick;
		chk(sys_rdata, e);
	endtask
	// every dsp op targets accumulator one
	task automatic op(input logic c, input logic nf, input logic [39:0] r, input logic cy,
		input logic [3:0] m);
		dsp_res = '{1'h1, c, nf, 1'h1, dsp_regs_pkg::DST_ACC1, r, cy, m[3], m[2], m[1], m[0]};
		tick;
		dsp_res.valid = 1'h0;
	endtask
	task automatic conclude;
		if (fails == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		{loop_set_begin, loop_set_finish, pc_load, status_we, legacy_mac_we} = '0;
		{parallel_mul_op, call_taken, cwe, loop_disp, legacy_mac_data} = '0;
		{exec_pc, pc_target, status_wdata, call_return_addr, cdata} = '0;
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'h0;
		foreach (rows[i]) begin
			sysw(dsp_regs_pkg::SYS_FLAGS, {28'h0, rows[i].cs, 1'h0});
			op(1'h0, 1'h0, rows[i].r, rows[i].cy, rows[i].cmp);
			chk(dsp_flags_reg, {24'h0, rows[i].e});
			chk(accumulator_one, rows[i].r);
			chk(dsp_cond_flag, rows[i].e[0]);
		end
		// load then store each control register back to back
		for (int i = 0; i < 3; i++) begin
			ctrl_req = '{1'h1, 1'h0, dsp_regs_pkg::ctrl_sel_t'(i),
				dsp_regs_pkg::ADDR_POST_INC, 32'hA000_0000 + i, 32'h0000_1000};
			tick;
			chk(ctrl_ptr_next, 32'h0000_1004);
			ctrl_req = '{1'h0, 1'h1, dsp_regs_pkg::ctrl_sel_t'(i),
				dsp_regs_pkg::ADDR_PRE_DEC, 32'h0, 32'h0000_1000};
			tick;
			chk(ctrl_rdata, 32'hA000_0000 + i);
			chk(ctrl_ptr_next, 32'h0000_0FFC);
		end
		ctrl_req = '0;
		chk(wrap_bounds, 32'hA000_0002);
		exec_pc = 32'h0000_0100;
		loop_disp = 12'hFFE;
		loop_set_begin = 1'h1;
		tick;
		chk(loop_begin_addr, 32'h0000_00FC);
		loop_set_begin = 1'h0;
		loop_set_finish = 1'h1;
		loop_disp = 12'h7FF;
		tick;
		chk(loop_finish_addr, 32'h0000_10FE);
		loop_set_finish = 1'h0;
		rd(dsp_regs_pkg::SYS_PC, 32'h0000_0104);
		// a second mac write under parallel multiply must be dropped
		legacy_mac_we = 1'h1;
		legacy_mac_data = 64'h1111_2222_3333_4444;
		tick;
		parallel_mul_op = 1'h1;
		legacy_mac_data = 64'h5555_6666_7777_8888;
		tick;
		{legacy_mac_we, parallel_mul_op} = '0;
		rd(dsp_regs_pkg::SYS_MAC_HIGH, 32'h1111_2222);
		rd(dsp_regs_pkg::SYS_MAC_LOW, 32'h3333_4444);
		sysw(dsp_regs_pkg::SYS_MAC_LOW, 32'h0000_0DEF);
		rd(dsp_regs_pkg::SYS_MAC_LOW, 32'h0000_0DEF);
		call_taken = 1'h1;
		call_return_addr = 32'h0000_0ABC;
		tick;
		call_taken = 1'h0;
		rd(dsp_regs_pkg::SYS_RETURN, 32'h0000_0ABC);
		sysw(dsp_regs_pkg::SYS_ACC0, 32'h8000_0001);
		chk(accumulator_zero, 40'hFF_8000_0001);
		rd(dsp_regs_pkg::SYS_ACC0, 32'h8000_0001);
		for (int i = 5; i < 9; i++) begin
			sysw(dsp_regs_pkg::sys_sel_t'(i), 32'h0000_00A0 + i);
			rd(dsp_regs_pkg::sys_sel_t'(i), 32'h0000_00A0 + i);
		end
		// conditional op suppressed with the condition flag clear, then taken
		sysw(dsp_regs_pkg::SYS_FLAGS, 32'h0000_0004);
		op(1'h1, 1'h0, 40'h00_0000_0077, 1'h0, 4'h0);
		chk(accumulator_one, 40'h00_0000_0005);
		chk(dsp_exec_taken, 1'h0);
		chk(dsp_flags_reg, 32'h0000_0004);
		sysw(dsp_regs_pkg::SYS_FLAGS, 32'h0000_0005);
		chk(dsp_cond_flag, 1'h1);
		op(1'h1, 1'h0, 40'h00_0000_0077, 1'h0, 4'h0);
		chk(accumulator_one, 40'h00_0000_0077);
		chk(dsp_exec_taken, 1'h1);
		tick;
		op(1'h0, 1'h1, 40'h00_0000_0000, 1'h0, 4'h0);
		chk(dsp_flags_reg, 32'h0000_0005);
		// select code 110 is never issued by the core model, so the flags keep their value
		sysw(dsp_regs_pkg::SYS_FLAGS, 32'h0000_000C);
		chk(dsp_flags_reg, 32'h0000_0005);
		status_we = 1'h1;
		status_wdata = 32'hFFFF_FFFF;
		tick;
		status_we = 1'h0;
		chk(cpu_status_word, 32'h0FFF_0FFF);
		// reset again in mid-run
		sys_rst = 1'h1;
		tick;
		sys_rst = 1'h0;
		chk(cpu_status_word, 32'h0000_00F0);
		chk(dsp_flags_reg, 32'h0000_0000);
		conclude;
	end
endmodule
